/* hdl/sic_irq_config.sv */
// Secondary interrupt enables, priorities and interrupt pin configuration
`timescale 1ns/100ps
`default_nettype none
// How it works
// RULE1 - Bit 6 sets clock-calendar priority
// RULE2 - Bit 4 sets serial-port priority
// RULE3 - Bit 3 enables metering interrupt
// RULE4 - Bit 2 enables clock-calendar interrupt
// RULE5 - Bit 1 enables supply-monitor interrupt
// RULE6 - Bit 0 enables serial-port interrupt
// RULE7 - Bit 7 drives calibration output pin
// RULE8 - Bits 6-5 pick calibration frequency, window
// RULE9 - Bits 3-1 configure external pin one
// RULE10 - Bit 0 enables external pin zero
// RULE11 - Global enable gates every source
// RULE12 - Supply monitor alone at top level
// RULE13 - High preempts low, never same level
// RULE14 - Request needs pending, enable, global enable
module sic_irq_config (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // SFR access from the core
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_wr_in,
  output logic      [7:0] sfr_rdata_out,
  output logic            sfr_hit_out,
  // Global enable from the primary enable register
  input  wire logic       global_irq_enable_in,
  // Pending flags: metering, clock calendar, supply monitor, serial port
  input  wire logic [3:0] pending_in,
  // Service handshake with the core
  input  wire logic       irq_ack_in,
  input  wire logic       irq_return_in,
  output logic            irq_req_out,
  output logic      [1:0] irq_src_out,
  output logic      [1:0] irq_level_out,
  output logic      [1:0] active_level_out,
  // Calibration output
  input  wire logic [3:0] cal_tick_in,
  output logic            calibration_output_enable_out,
  output logic            cal_pin_out,
  output logic            cal_long_window_out,
  // External pin configuration
  output logic            ext_pin_one_gpio_out,
  output logic            battery_control_function_out,
  output logic            external_irq_pin_one_en_out,
  output logic            external_irq_pin_zero_en_out
);
  logic [7:0] sec_q;
  logic [7:0] sec_d;
  logic [7:0] pin_q;
  logic [7:0] pin_d;
  logic [1:0] stack_q [0:2];
  logic [1:0] depth_q;
  logic [1:0] depth_d;
  logic       cal_q;
  logic [1:0] src_q;
  logic [1:0] lvl_q;
  logic       req_q;

  // SFR decode
  wire hit_sec = (sfr_addr_in == sic_pkg::SFR_SECONDARY_IRQ);
  wire hit_pin = (sfr_addr_in == sic_pkg::SFR_PIN_CONFIG);
  assign sfr_hit_out = hit_sec | hit_pin;
  assign sfr_rdata_out = hit_sec ? sec_q : (hit_pin ? pin_q : 8'h00);
  assign sec_d = (sfr_wr_in && hit_sec) ? sfr_wdata_in : sec_q;
  assign pin_d = (sfr_wr_in && hit_pin) ? (sfr_wdata_in & sic_pkg::PIN_CONFIG_WMASK) : pin_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sec_q <= sic_pkg::SECONDARY_IRQ_RESET;
      pin_q <= sic_pkg::PIN_CONFIG_RESET;
    end else begin
      sec_q <= sec_d;
      pin_q <= pin_d;
    end
  end

  // Per-source enables and priorities
  wire [3:0] src_en;
  wire [3:0] src_high;
  assign src_en[sic_pkg::SRC_METER]    = sec_q[sic_pkg::BIT_METERING_EN];       // RULE3
  assign src_en[sic_pkg::SRC_CLOCK]    = sec_q[sic_pkg::BIT_CLOCK_CALENDAR_EN]; // RULE4
  assign src_en[sic_pkg::SRC_SUPPLY]   = sec_q[sic_pkg::BIT_SUPPLY_MONITOR_EN]; // RULE5
  assign src_en[sic_pkg::SRC_SERIAL]   = sec_q[sic_pkg::BIT_SERIAL_PORT_EN];    // RULE6
  // Metering priority sits in the primary priority register, outside
  assign src_high[sic_pkg::SRC_METER]  = 1'b0;
  assign src_high[sic_pkg::SRC_CLOCK]  = sec_q[sic_pkg::BIT_CLOCK_CALENDAR_PRIO]; // RULE1
  assign src_high[sic_pkg::SRC_SUPPLY] = 1'b0;
  assign src_high[sic_pkg::SRC_SERIAL] = sec_q[sic_pkg::BIT_SERIAL_PORT_PRIO];  // RULE2

  wire [3:0] req;
  wire [3:0] req_hi;
  wire [3:0] req_lo;
  genvar g;
  generate
    for (g = 0; g < sic_pkg::NSRC; g++) begin : g_src
      sic_source_gate u_gate (
        .pending_in   (pending_in[g]),
        .enable_in    (src_en[g]),
        .global_en_in (global_irq_enable_in), // RULE11
        .high_prio_in (src_high[g]),
        .req_out      (req[g]),
        .req_high_out (req_hi[g]),
        .req_low_out  (req_lo[g])
      );
    end
  endgenerate

  // Winner: supply monitor, then high, then low; lowest index polls first
  wire sup_req = req[sic_pkg::SRC_SUPPLY];                        // RULE12
  wire [3:0] hi_nosup = req_hi;
  wire [3:0] lo_nosup = req_lo & ~(4'h1 << sic_pkg::SRC_SUPPLY);
  wire [3:0] pick = (|hi_nosup) ? hi_nosup : lo_nosup;           // RULE13
  wire [1:0] pick_src = pick[0] ? 2'h0 : (pick[1] ? 2'h1 : (pick[2] ? 2'h2 : 2'h3));
  wire [1:0] win_src = sup_req ? 2'(sic_pkg::SRC_SUPPLY) : pick_src;
  wire [1:0] win_lvl = sup_req ? sic_pkg::SIC_LVL_SUPPLY :
                       ((|hi_nosup) ? sic_pkg::SIC_LVL_HIGH :
                       ((|lo_nosup) ? sic_pkg::SIC_LVL_LOW : sic_pkg::SIC_LVL_NONE));
  wire [1:0] run_lvl = (depth_q == 2'h0) ? sic_pkg::SIC_LVL_NONE : stack_q[depth_q - 2'h1];
  // Only a strictly higher level may preempt the running routine
  wire       may_take = (win_lvl > run_lvl);                     // RULE13
  wire       take = req_q & irq_ack_in;

  always_comb begin
    depth_d = depth_q;
    if (take && depth_q != 2'h3) begin
      depth_d = depth_q + 2'h1;
    end else if (irq_return_in && depth_q != 2'h0) begin
      depth_d = depth_q - 2'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      depth_q <= 2'h0;
      req_q   <= 1'b0;
      src_q   <= 2'h0;
      lvl_q   <= sic_pkg::SIC_LVL_NONE;
    end else begin
      depth_q <= depth_d;
      req_q   <= may_take & ~take; // RULE14
      src_q   <= win_src;
      lvl_q   <= win_lvl;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stack_q[0] <= sic_pkg::SIC_LVL_NONE;
      stack_q[1] <= sic_pkg::SIC_LVL_NONE;
      stack_q[2] <= sic_pkg::SIC_LVL_NONE;
    end else if (take && depth_q != 2'h3) begin
      stack_q[depth_q] <= lvl_q;
    end
  end

  assign irq_req_out      = req_q;
  assign irq_src_out      = src_q;
  assign irq_level_out    = lvl_q;
  assign active_level_out = run_lvl;

  // Calibration output
  wire [1:0] fsel = pin_q[sic_pkg::BIT_CAL_FSEL_HI:sic_pkg::BIT_CAL_FSEL_LO]; // RULE8
  wire       cal_src = cal_tick_in[fsel];
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cal_q <= 1'b0;
    end else begin
      cal_q <= pin_q[sic_pkg::BIT_CAL_OUT_EN] & cal_src; // RULE7
    end
  end
  assign calibration_output_enable_out = pin_q[sic_pkg::BIT_CAL_OUT_EN];
  assign cal_pin_out = cal_q;
  assign cal_long_window_out = (fsel == sic_pkg::CAL_1HZ_LONG) ||
                               (fsel == sic_pkg::CAL_512HZ_LONG); // RULE8

  // External pin functions
  wire [2:0] p1 = pin_q[sic_pkg::BIT_PIN_ONE_HI:sic_pkg::BIT_PIN_ONE_LO];
  assign ext_pin_one_gpio_out         = (p1[1:0] == 2'h0);   // RULE9
  assign battery_control_function_out = (p1[1:0] == 2'h1);   // RULE9
  assign external_irq_pin_one_en_out  = (p1[2:1] == 2'h3);   // RULE9
  assign external_irq_pin_zero_en_out = pin_q[sic_pkg::BIT_PIN_ZERO_EN]; // RULE10
endmodule
`default_nettype wire

/* hdl/sic_source_gate.sv */
// Per-source request gating and priority sort
`timescale 1ns/100ps
`default_nettype none
module sic_source_gate (
  // Source state
  input  wire logic pending_in,
  input  wire logic enable_in,
  input  wire logic global_en_in,
  input  wire logic high_prio_in,
  // Gated requests
  output logic      req_out,
  output logic      req_high_out,
  output logic      req_low_out
);
  assign req_out      = pending_in & enable_in & global_en_in; // RULE14
  assign req_high_out = req_out & high_prio_in;
  assign req_low_out  = req_out & ~high_prio_in;
endmodule
`default_nettype wire

/* shared/sic_pkg.sv */
// Package: SFR addresses, field positions, reset values and priority levels
package sic_pkg;
  // SFR addresses in the core's special-function space
  localparam logic [7:0] SFR_SECONDARY_IRQ = 8'hA9;
  localparam logic [7:0] SFR_PIN_CONFIG    = 8'hFF;
  // Reset values
  localparam logic [7:0] SECONDARY_IRQ_RESET = 8'hA0;
  localparam logic [7:0] PIN_CONFIG_RESET    = 8'h00;
  // Secondary interrupt register fields
  localparam int BIT_CLOCK_CALENDAR_PRIO = 6;
  localparam int BIT_SERIAL_PORT_PRIO    = 4;
  localparam int BIT_METERING_EN         = 3;
  localparam int BIT_CLOCK_CALENDAR_EN   = 2;
  localparam int BIT_SUPPLY_MONITOR_EN   = 1;
  localparam int BIT_SERIAL_PORT_EN      = 0;
  // Pin configuration register fields
  localparam int BIT_CAL_OUT_EN   = 7;
  localparam int BIT_CAL_FSEL_HI  = 6;
  localparam int BIT_CAL_FSEL_LO  = 5;
  localparam int BIT_PIN_ONE_HI   = 3;
  localparam int BIT_PIN_ONE_LO   = 1;
  localparam int BIT_PIN_ZERO_EN  = 0;
  localparam logic [7:0] PIN_CONFIG_WMASK = 8'hEF;
  // Calibration select codes
  localparam logic [1:0] CAL_1HZ_LONG    = 2'h0;
  localparam logic [1:0] CAL_512HZ_LONG  = 2'h1;
  localparam logic [1:0] CAL_500HZ_SHORT = 2'h2;
  localparam logic [1:0] CAL_16KHZ_SHORT = 2'h3;
  // Source count and indices
  localparam int NSRC       = 4;
  localparam int SRC_METER  = 0;
  localparam int SRC_CLOCK  = 1;
  localparam int SRC_SUPPLY = 2;
  localparam int SRC_SERIAL = 3;
  // Service levels, running level encoding
  typedef enum logic [1:0] {
    SIC_LVL_NONE,
    SIC_LVL_LOW,
    SIC_LVL_HIGH,
    SIC_LVL_SUPPLY
  } sic_level_t;
endpackage

/* verification/sic_core_model.sv */
// Core-side model: acknowledges requests at once or after a stall
`timescale 1ns/100ps
`default_nettype none
module sic_core_model (
  input  wire logic clk_in, rst_in, req_in, slow_in,
  output logic      ack_out
);
  logic [1:0] wait_q;
  always_ff @(posedge clk_in) begin
    if (rst_in || !req_in) wait_q <= slow_in ? 2'h3 : 2'h0;
    else if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
  end
  assign ack_out = req_in && wait_q == 2'h0;
endmodule
`default_nettype wire

/* verification/sic_irq_config_properties.sv */
// Checker: request gating, nesting and pin configuration decodes
`timescale 1ns/100ps
`default_nettype none
module sic_irq_config_properties (
  input wire logic       clk_in, rst_in, sfr_wr_in, global_irq_enable_in, irq_ack_in,
  input wire logic       irq_req_out, calibration_output_enable_out, cal_long_window_out,
  input wire logic       external_irq_pin_one_en_out, external_irq_pin_zero_en_out,
  input wire logic [7:0] sfr_addr_in, sfr_wdata_in,
  input wire logic [3:0] pending_in,
  input wire logic [1:0] irq_src_out, irq_level_out, active_level_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire logic pin_wr = sfr_wr_in && sfr_addr_in == 8'hFF;
  a_req_global_gate: assert property ($rose(irq_req_out) |-> $past(global_irq_enable_in))
    else $error("request without global enable");
  a_req_has_pending: assert property ($rose(irq_req_out)
    |-> ($past(pending_in) & (4'h1 << irq_src_out)) != 4'h0) else $error("request not pending");
  a_supply_top_level: assert property (irq_req_out
    |-> (irq_src_out == 2'h2) == (irq_level_out == 2'h3)) else $error("supply level wrong");
  a_higher_level_only: assert property ($rose(irq_req_out) |-> irq_level_out > active_level_out)
    else $error("request not above running level");
  a_ack_pushes_level: assert property (irq_ack_in && irq_req_out
    |=> !irq_req_out && active_level_out == $past(irq_level_out)) else $error("ack not taken");
  a_pin_reset_value: assert property ($past(rst_in)
    |-> !calibration_output_enable_out && !external_irq_pin_zero_en_out) else $error("reset value");
  a_cal_write_window: assert property (pin_wr |=> {calibration_output_enable_out,
    cal_long_window_out} == {$past(sfr_wdata_in[7]), !$past(sfr_wdata_in[6])}) else $error("cal");
  a_pin_zero_write: assert property (pin_wr
    |=> external_irq_pin_zero_en_out == $past(sfr_wdata_in[0])) else $error("pin zero decode");
  a_pin_one_write: assert property (pin_wr
    |=> external_irq_pin_one_en_out == ($past(sfr_wdata_in[3:2]) == 2'h3)) else $error("pin one");
  c_supply_preempt: cover property (irq_req_out && irq_level_out == 2'h3 && active_level_out == 2'h2);
  c_ack_taken: cover property (irq_ack_in && irq_req_out);
  c_pin_write: cover property (pin_wr);
endmodule
bind sic_irq_config sic_irq_config_properties sic_irq_config_properties_inst (.*);
`default_nettype wire

/* verification/test_secondary_irq_and_pin_config.sv */
// Testbench: register access, pin decodes and interrupt priority
`timescale 1ns/100ps
`default_nettype none
module test_secondary_irq_and_pin_config;
  logic       clk_in, rst_in, sfr_wr_in, global_irq_enable_in, irq_ack_in, irq_return_in, slow;
  logic       irq_req_out, sfr_hit_out, calibration_output_enable_out, cal_pin_out;
  logic       cal_long_window_out, ext_pin_one_gpio_out, battery_control_function_out;
  logic       external_irq_pin_one_en_out, external_irq_pin_zero_en_out;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
  logic [3:0] pending_in, cal_tick_in;
  logic [1:0] irq_src_out, irq_level_out, active_level_out;
  int         num_errors = 0;
  int         checked = 0;
  sic_irq_config sic_irq_config_inst (.*);
  sic_core_model sic_core_model_inst (.clk_in, .rst_in, .req_in(irq_req_out), .slow_in(slow),
                                      .ack_out(irq_ack_in));
  always #25 clk_in = ~clk_in;
  task chk(input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t ns: %h, expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
    @(negedge clk_in);
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge clk_in);
    sfr_addr_in <= a;
    @(negedge clk_in);
    chk(sfr_rdata_out, e);
    chk(8'(sfr_hit_out), 8'(a == 8'hA9 || a == 8'hFF));
  endtask
  task grant(input logic [1:0] s, l);
    int n;
    n = 0;
    while (irq_ack_in !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    chk(8'({irq_req_out, irq_src_out, irq_level_out}), 8'({1'b1, s, l}));
    @(posedge clk_in);
    pending_in[s] <= 1'b0;
    @(negedge clk_in);
    chk(8'(active_level_out), 8'(l));
  endtask
  task ret;
    @(posedge clk_in);
    irq_return_in <= 1'b1;
    @(posedge clk_in);
    irq_return_in <= 1'b0;
  endtask
  task quiet;
    repeat (5) begin
      @(negedge clk_in);
      chk(8'(irq_req_out), 8'h0);
    end
  endtask
  task t_regs;
    rd(8'hA9, 8'hA0);
    rd(8'hFF, 8'h00);
    rd(8'h3C, 8'h00);
    for (int i = 0; i < 8; i++) begin
      cal_tick_in <= 4'h1 << i[1:0];
      wr(8'hFF, {1'b1, i[1:0], 1'b0, i[2:0], i[0]});
      @(negedge clk_in);
      chk(8'({calibration_output_enable_out, cal_pin_out, cal_long_window_out}), 8'({2'h3, !i[1]}));
      chk(8'({ext_pin_one_gpio_out, battery_control_function_out, external_irq_pin_one_en_out,
              external_irq_pin_zero_en_out}), 8'({i[1:0] == 0, i[1:0] == 1, i[2:1] == 3, i[0]}));
    end
    wr(8'hFF, 8'hFF);
    rd(8'hFF, 8'hEF);
    wr(8'hFF, 8'h00);
    @(negedge clk_in);
    chk(8'(cal_pin_out), 8'h0);
    $display("t_regs done");
  endtask
  task t_mask;
    wr(8'hA9, 8'h0F);
    pending_in <= 4'hF;
    quiet();
    wr(8'hA9, 8'h00);
    global_irq_enable_in <= 1'b1;
    quiet();
    pending_in <= 4'h0;
    $display("t_mask done");
  endtask
  task t_src;
    for (int k = 0; k < 4; k++) begin
      slow <= k[0];
      wr(8'hA9, 8'h08 >> k);
      pending_in[k] <= 1'b1;
      grant(k[1:0], (k == 2) ? 2'h3 : 2'h1);
      ret();
    end
    $display("t_src done");
  endtask
  task t_prio;
    wr(8'hA9, 8'h4F);
    pending_in <= 4'hA;
    grant(2'h1, 2'h2);
    quiet();
    pending_in[2] <= 1'b1;
    grant(2'h2, 2'h3);
    ret();
    ret();
    grant(2'h3, 2'h1);
    ret();
    wr(8'hA9, 8'h1F);
    pending_in <= 4'hA;
    grant(2'h3, 2'h2);
    ret();
    grant(2'h1, 2'h1);
    ret();
    $display("t_prio done");
  endtask
  task close_out;
    $display("errors %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    {clk_in, sfr_wr_in, global_irq_enable_in, irq_return_in, slow} = '0;
    {sfr_addr_in, sfr_wdata_in, pending_in, cal_tick_in} = '0;
    rst_in = 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_mask();
    t_src();
    t_prio();
    close_out();
  end
  initial begin
    #(2000 * 50);
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
